/* shared/iar_pkg.sv */
// Package for the identity and own bus address register group.
// Assumes a byte-wide register port driven by the serial interface engine.
package iar_pkg;
	localparam logic [7:0] ADDR_REVISION_HI = 8'h02;
	localparam logic [7:0] ADDR_ID_MID = 8'h03;
	localparam logic [7:0] ADDR_ID_LO_CFG_HI = 8'h04;
	localparam logic [7:0] ADDR_CFG_LO = 8'h05;
	localparam logic [7:0] ADDR_OWN_ADDR = 8'h06;
	localparam logic [7:0] ADDR_RSVD = 8'h07;
	// Arbitrary neutral identity values
	localparam logic [3:0] RST_REVISION = 4'h0;
	localparam logic [15:0] RST_PART_ID = 16'h00A5;
	localparam logic [10:0] RST_CFG_CODE = 11'h000;
	// Generic configurations answer at 1111100b; upper five bits stored
	localparam logic [4:0] RST_ADDR_UPPER = 5'h1F;
	localparam logic [6:0] GENERIC_TARGET_ADDR = 7'h7C;
	localparam logic [7:0] RSVD_READ = 8'h00;

	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} iar_req_t;
endpackage

/* rtl/iar_regs.sv */
// Identity and own bus address register group.
// Assumes the serial engine issues one-cycle write strobes and samples read data combinationally by offset.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Keep eleven-bit factory configuration code
// - Configuration code writable; reads return written value, except bit zero of the low byte, which always reads one
// - Address bit one mirrors upper strap
// - Address bit zero mirrors lower strap
// - Generic parts default to address 1111100b
module iar_regs (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire iar_pkg::iar_req_t i_req,
	input wire logic i_address_strap_upper,
	input wire logic i_address_strap_lower,
	output logic [7:0] o_rdata,
	output logic [6:0] o_own_bus_target_address
);
	import iar_pkg::*;

	logic [3:0] silicon_revision_ff;
	logic [15:0] part_identifier_ff;
	logic [10:0] cfg_code_ff;
	logic [4:0] addr_upper_ff;
	logic [7:0] rsvd_ff;

	////////////////////////////////////////////////////////////////////////////
	// Write decode shared by the checks below
	function automatic logic write_hit(input logic ce, input iar_req_t req, input logic [7:0] offset);
		return ce && req.wr && (req.addr == offset);
	endfunction

	logic hit_revision;
	logic hit_id_mid;
	logic hit_id_lo;
	logic hit_cfg_lo;
	logic hit_own;
	logic hit_rsvd;

	assign hit_revision = write_hit(i_ce, i_req, ADDR_REVISION_HI);
	assign hit_id_mid = write_hit(i_ce, i_req, ADDR_ID_MID);
	assign hit_id_lo = write_hit(i_ce, i_req, ADDR_ID_LO_CFG_HI);
	assign hit_cfg_lo = write_hit(i_ce, i_req, ADDR_CFG_LO);
	assign hit_own = write_hit(i_ce, i_req, ADDR_OWN_ADDR);
	assign hit_rsvd = write_hit(i_ce, i_req, ADDR_RSVD);

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			silicon_revision_ff <= RST_REVISION;
			part_identifier_ff <= RST_PART_ID;
		end else if (i_ce && i_req.wr) begin
			if (i_req.addr == ADDR_REVISION_HI) begin
				silicon_revision_ff <= i_req.wdata[7:4];
				part_identifier_ff[15:12] <= i_req.wdata[3:0];
			end
			if (i_req.addr == ADDR_ID_MID) begin
				part_identifier_ff[11:4] <= i_req.wdata;
			end
			if (i_req.addr == ADDR_ID_LO_CFG_HI) begin
				part_identifier_ff[3:0] <= i_req.wdata[7:4];
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cfg_code_ff <= RST_CFG_CODE;
		end else if (i_ce && i_req.wr) begin
			if (i_req.addr == ADDR_ID_LO_CFG_HI) begin
				cfg_code_ff[10:7] <= i_req.wdata[3:0];
			end
			if (i_req.addr == ADDR_CFG_LO) begin
				cfg_code_ff[6:0] <= i_req.wdata[7:1];
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			addr_upper_ff <= RST_ADDR_UPPER;
			rsvd_ff <= RSVD_READ;
		end else if (i_ce && i_req.wr) begin
			if (i_req.addr == ADDR_OWN_ADDR) begin
				addr_upper_ff <= i_req.wdata[6:2];
			end
			if (i_req.addr == ADDR_RSVD) begin
				rsvd_ff <= i_req.wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Strap bits are live, never stored
	assign o_own_bus_target_address = {addr_upper_ff, i_address_strap_upper, i_address_strap_lower};

	always_comb begin
		unique case (i_req.addr)
			ADDR_REVISION_HI: o_rdata = {silicon_revision_ff, part_identifier_ff[15:12]};
			ADDR_ID_MID: o_rdata = part_identifier_ff[11:4];
			ADDR_ID_LO_CFG_HI: o_rdata = {part_identifier_ff[3:0], cfg_code_ff[10:7]};
			ADDR_CFG_LO: o_rdata = {cfg_code_ff[6:0], 1'b1};
			ADDR_OWN_ADDR: o_rdata = {1'b0, o_own_bus_target_address};
			ADDR_RSVD: o_rdata = rsvd_ff;
			default: o_rdata = RSVD_READ;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	cfg_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && i_req.wr && i_req.addr == ADDR_CFG_LO |=> cfg_code_ff[6:0] == $past(i_req.wdata[7:1]))
		else $error("config code low not written");
	cfg_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_ce |=> $stable(cfg_code_ff))
		else $error("config code changed while frozen");
	addr_upper_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && i_req.wr && i_req.addr == ADDR_OWN_ADDR |=> o_own_bus_target_address[6:2] == $past(i_req.wdata[6:2]))
		else $error("address upper not written");
	strap_hi_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_own_bus_target_address[1] == i_address_strap_upper)
		else $error("bit one not following strap");
	strap_lo_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_own_bus_target_address[0] == i_address_strap_lower)
		else $error("bit zero not following strap");
	addr_reset_a: assert property (@(posedge i_clk)
		$fell(i_rst) |-> addr_upper_ff == GENERIC_TARGET_ADDR[6:2])
		else $error("address upper not generic after reset");
	read_cfg_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_req.addr == ADDR_CFG_LO |-> o_rdata == {cfg_code_ff[6:0], 1'b1})
		else $error("config code read wrong");
	read_id_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && i_req.wr && i_req.addr == ADDR_ID_MID ##1 i_req.addr == ADDR_ID_MID && !i_req.wr
		|-> o_rdata == $past(i_req.wdata))
		else $error("part id middle read wrong");

	////////////////////////////////////////////////////////////////////////////
	// Writes land in the addressed field one cycle later
	rev_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
		hit_revision |=> silicon_revision_ff == $past(i_req.wdata[7:4]))
		else $error("revision not written");
	id_hi_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
		hit_revision |=> part_identifier_ff[15:12] == $past(i_req.wdata[3:0]))
		else $error("part id upper not written");
	id_mid_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
		hit_id_mid |=> part_identifier_ff[11:4] == $past(i_req.wdata))
		else $error("part id middle not written");
	id_lo_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
		hit_id_lo |=> part_identifier_ff[3:0] == $past(i_req.wdata[7:4]))
		else $error("part id lower not written");
	cfg_hi_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
		hit_id_lo |=> cfg_code_ff[10:7] == $past(i_req.wdata[3:0]))
		else $error("config code upper not written");
	rsvd_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
		hit_rsvd |=> rsvd_ff == $past(i_req.wdata))
		else $error("reserved byte not written");

	////////////////////////////////////////////////////////////////////////////
	// Fields keep their value unless written
	rev_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_ce |=> $stable(silicon_revision_ff))
		else $error("revision changed while frozen");
	id_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_ce |=> $stable(part_identifier_ff))
		else $error("part id changed while frozen");
	addr_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_ce |=> $stable(addr_upper_ff))
		else $error("address upper changed while frozen");
	rsvd_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_ce |=> $stable(rsvd_ff))
		else $error("reserved byte changed while frozen");
	cfg_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!hit_id_lo && !hit_cfg_lo |=> $stable(cfg_code_ff))
		else $error("config code changed without write");
	addr_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!hit_own |=> $stable(addr_upper_ff))
		else $error("address upper changed without write");
	id_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!hit_revision && !hit_id_mid && !hit_id_lo |=> $stable(part_identifier_ff))
		else $error("part id changed without write");

	////////////////////////////////////////////////////////////////////////////
	// Read mux returns each field at its own offset
	read_rev_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_req.addr == ADDR_REVISION_HI |-> o_rdata == {silicon_revision_ff, part_identifier_ff[15:12]})
		else $error("revision read wrong");
	read_mid_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_req.addr == ADDR_ID_MID |-> o_rdata == part_identifier_ff[11:4])
		else $error("part id middle mux wrong");
	read_lo_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_req.addr == ADDR_ID_LO_CFG_HI |-> o_rdata == {part_identifier_ff[3:0], cfg_code_ff[10:7]})
		else $error("part id lower read wrong");
	cfg_lsb_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_req.addr == ADDR_CFG_LO |-> o_rdata[0] == 1'b1)
		else $error("config low marker bit wrong");
	read_own_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_req.addr == ADDR_OWN_ADDR |-> o_rdata == {1'b0, o_own_bus_target_address})
		else $error("own address read wrong");
	own_top_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_req.addr == ADDR_OWN_ADDR |-> o_rdata[7] == 1'b0)
		else $error("own address top bit set");
	read_rsvd_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_req.addr == ADDR_RSVD |-> o_rdata == rsvd_ff)
		else $error("reserved byte read wrong");
	read_unmapped_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!(i_req.addr inside {[ADDR_REVISION_HI:ADDR_RSVD]}) |-> o_rdata == RSVD_READ)
		else $error("unmapped read not zero");
	own_upper_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_own_bus_target_address[6:2] == addr_upper_ff)
		else $error("address upper not driven from field");

	////////////////////////////////////////////////////////////////////////////
	// Values seen at the first edge after reset
	cfg_reset_a: assert property (@(posedge i_clk)
		$fell(i_rst) |-> cfg_code_ff == RST_CFG_CODE)
		else $error("config code not reset");
	id_reset_a: assert property (@(posedge i_clk)
		$fell(i_rst) |-> part_identifier_ff == RST_PART_ID)
		else $error("part id not reset");
	addr_generic_a: assert property (@(posedge i_clk)
		$fell(i_rst) && !i_address_strap_upper && !i_address_strap_lower |-> o_own_bus_target_address == GENERIC_TARGET_ADDR)
		else $error("generic address not seen after reset");
endmodule

/* verif/iar_host.sv */
// Bus controller model that drives the register request port.
// Assumes tasks are called just after a rising clock edge.
`timescale 1ns/10ps
module iar_host (
	input wire logic i_clk,
	output iar_pkg::iar_req_t o_req
);
	import iar_pkg::*;
	initial o_req = '0;
	// One-cycle write strobe, then released data is inverted
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		o_req <= '{wr: 1'b1, addr: a, wdata: d};
		@(posedge i_clk);
		o_req <= '{wr: 1'b0, addr: a, wdata: ~d};
		@(posedge i_clk);
	endtask
	task automatic point(input logic [7:0] a);
		o_req <= '{wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge i_clk);
	endtask
endmodule

/* verif/iar_regs_bench.sv */
// Bench for the identity and own bus address register group.
// Assumes the host model and the design package.
`timescale 1ns/10ps
module iar_regs_bench;
	import iar_pkg::*;
	logic i_clk = 0, i_rst = 1, i_ce = 1, su = 0, sl = 0;
	iar_req_t req;
	logic [7:0] rd;
	logic [6:0] own;
	int bad_count = 0, check_count = 0, cyc = 0;
	always #10 i_clk = ~i_clk;
	iar_host host (.i_clk(i_clk), .o_req(req));
	iar_regs dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_req(req), .i_address_strap_upper(su),
		.i_address_strap_lower(sl), .o_rdata(rd), .o_own_bus_target_address(own));
	task automatic stop_test;
		if (bad_count == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic [7:0] a, input logic [7:0] e, input logic [7:0] s);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value at %h expected %h seen %h", a, e, s);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		host.point(a);
		cmp(a, e, rd);
	endtask
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			bad_count++;
			stop_test();
		end
	end
	initial begin
		repeat (16) @(posedge i_clk);
		i_rst <= 0;
		@(posedge i_clk);
		rd_chk(ADDR_REVISION_HI, {RST_REVISION, RST_PART_ID[15:12]});
		rd_chk(ADDR_ID_MID, RST_PART_ID[11:4]);
		rd_chk(ADDR_ID_LO_CFG_HI, {RST_PART_ID[3:0], RST_CFG_CODE[10:7]});
		rd_chk(ADDR_CFG_LO, {RST_CFG_CODE[6:0], 1'b1});
		rd_chk(ADDR_OWN_ADDR, 8'h7C);
		cmp(8'hFF, 8'h7C, {1'b0, own});
		host.put(ADDR_CFG_LO, 8'hAA);
		rd_chk(ADDR_CFG_LO, 8'hAB);
		host.put(ADDR_ID_LO_CFG_HI, 8'h3C);
		rd_chk(ADDR_ID_LO_CFG_HI, 8'h3C);
		host.put(ADDR_ID_MID, 8'h5A);
		rd_chk(ADDR_ID_MID, 8'h5A);
		host.put(ADDR_RSVD, 8'hC3);
		rd_chk(ADDR_RSVD, 8'hC3);
		su <= 1;
		host.put(ADDR_OWN_ADDR, 8'hFF);
		rd_chk(ADDR_OWN_ADDR, 8'h7E);
		su <= 0;
		sl <= 1;
		host.put(ADDR_OWN_ADDR, 8'h28);
		rd_chk(ADDR_OWN_ADDR, 8'h29);
		cmp(8'hFF, 8'h29, {1'b0, own});
		host.put(8'h08, 8'h55);
		rd_chk(8'h08, 8'h00);
		i_ce <= 0;
		host.put(ADDR_CFG_LO, 8'h10);
		rd_chk(ADDR_CFG_LO, 8'hAB);
		i_ce <= 1;
		i_rst <= 1;
		repeat (2) @(posedge i_clk);
		i_rst <= 0;
		@(posedge i_clk);
		rd_chk(ADDR_CFG_LO, {RST_CFG_CODE[6:0], 1'b1});
		rd_chk(ADDR_OWN_ADDR, 8'h7D);
		stop_test();
	end
endmodule
